// >>> core/ssu1_core.v
// synchronous serial unit: registers, shift engine and tail logic
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "ssu1_regs.vh"
module ssu1_core (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register port
  input wire [15:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rd_data,
  // serial clock pin
  input wire serial_clock_pin_in,
  output reg serial_clock_pin_out,
  output reg serial_clock_pin_oe,
  // serial data pins
  input wire serial_in_pin,
  output reg serial_out_pin,
  // status
  output reg busy
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_TAIL = 2'h2;
  localparam ST_CONT = 2'h3;

  reg [1:0] state;
  reg [7:0] mode;
  reg [7:0] data_upper_byte;
  reg [7:0] data_lower_byte;
  reg done;
  reg [3:0] bit_count;
  reg [1:0] tail_half;
  reg sck_in_q;
  reg sck_in_prev;
  wire half_tick;
  wire [1:0] op_mode;
  wire tail_mark_enable;
  wire tail_kind_select;
  wire clock_source_select;
  wire [2:0] prescale_sel;
  wire [3:0] last_bit;
  wire ext_fall;
  wire ext_rise;
  wire int_fall;
  wire int_rise;
  wire shift_out_edge;
  wire sample_edge;
  wire wr_mode;
  wire wr_stat;
  wire wr_upper;
  wire wr_lower;
  wire start_req;
  wire stop_req;
  wire finish;

  // address match used by both strobes
  function ssu1_hit;
    input [15:0] a;
    input [15:0] target;
    begin
      ssu1_hit = (a == target);
    end
  endfunction

  assign op_mode = mode[`SSU1_OP_MODE_HI:`SSU1_OP_MODE_LO];
  assign tail_mark_enable = mode[`SSU1_TAIL_MARK_ENABLE];
  assign tail_kind_select = mode[`SSU1_TAIL_KIND_SELECT];
  assign clock_source_select = mode[`SSU1_CLOCK_SOURCE_SELECT];
  assign prescale_sel = mode[`SSU1_PRESCALE_SEL_2:`SSU1_PRESCALE_SEL_0];

  assign last_bit = (op_mode == `SSU1_OP_16BIT) ? `SSU1_LAST_BIT_16 : `SSU1_LAST_BIT_8;

  assign wr_mode = wr_en && ssu1_hit(addr, `SSU1_ADDR_MODE);
  assign wr_stat = wr_en && ssu1_hit(addr, `SSU1_ADDR_STAT);
  assign wr_upper = wr_en && ssu1_hit(addr, `SSU1_ADDR_UPPER);
  assign wr_lower = wr_en && ssu1_hit(addr, `SSU1_ADDR_LOWER);

  assign start_req = wr_stat && wr_data[`SSU1_STAT_RUN] && (op_mode != `SSU1_OP_RSVD);
  assign stop_req = wr_stat && !wr_data[`SSU1_STAT_RUN];

  // prescaler runs while the engine is active
  ssu1_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(busy),
    .sel(prescale_sel),
    .half_tick(half_tick)
  );

  always @(posedge ref_clk) begin
    if (rst) begin
      sck_in_q <= 1'b1;
      sck_in_prev <= 1'b1;
    end else begin
      sck_in_q <= serial_clock_pin_in;
      sck_in_prev <= sck_in_q;
    end
  end

  // edges of a slow external clock and of the internal clock
  assign ext_fall = sck_in_prev && !sck_in_q;
  assign ext_rise = !sck_in_prev && sck_in_q;
  assign int_fall = half_tick && serial_clock_pin_out;
  assign int_rise = half_tick && !serial_clock_pin_out;

  // edge source by clock source bit
  assign shift_out_edge = clock_source_select ? ext_fall : int_fall;
  assign sample_edge = clock_source_select ? ext_rise : int_rise;
  assign finish = (state == ST_SHIFT) && sample_edge && (bit_count == last_bit);

  always @(posedge ref_clk) begin
    if (rst) begin
      mode <= `SSU1_MODE_RESET;
    end else if (wr_mode && !busy) begin
      mode <= wr_data;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      serial_clock_pin_oe <= 1'b1;
    end else begin
      serial_clock_pin_oe <= !clock_source_select;
    end
  end

  // transfer sequencer
  always @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      bit_count <= 4'h0;
      tail_half <= 2'h0;
      serial_clock_pin_out <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          serial_clock_pin_out <= 1'b1;
          bit_count <= 4'h0;
          tail_half <= 2'h0;
          if (start_req) begin
            busy <= 1'b1;
            if (op_mode == `SSU1_OP_CONT) begin
              state <= ST_CONT;
            end else begin
              state <= ST_SHIFT;
            end
          end
        end
        ST_SHIFT: begin
          // serial clock toggles per half period
          if (!clock_source_select && half_tick) begin
            serial_clock_pin_out <= !serial_clock_pin_out;
          end
          if (sample_edge) begin
            bit_count <= bit_count + 4'h1;
          end
          if (finish) begin
            if (tail_mark_enable) begin
              state <= ST_TAIL;
            end else begin
              state <= ST_IDLE;
              busy <= 1'b0;
            end
          end
        end
        ST_TAIL: begin
          serial_clock_pin_out <= 1'b1;
          if (half_tick) begin
            tail_half <= tail_half + 2'h1;
            if (tail_half == 2'h1) begin
              state <= ST_IDLE;
              busy <= 1'b0;
            end
          end
        end
        ST_CONT: begin
          if (half_tick) begin
            serial_clock_pin_out <= !serial_clock_pin_out;
          end
          if (stop_req) begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // serial output level and extended data bit
  always @(posedge ref_clk) begin
    if (rst) begin
      serial_out_pin <= 1'b1;
    end else if (state == ST_SHIFT && shift_out_edge) begin
      // next bit out, low bit first
      serial_out_pin <= data_lower_byte[0];
    end else if (state == ST_TAIL) begin
      // latch tail high, hold tail low
      serial_out_pin <= tail_kind_select;
    end else if (wr_stat) begin
      serial_out_pin <= wr_data[`SSU1_STAT_EXT_DATA];
    end
  end

  // data byte registers, no reset value
  always @(posedge ref_clk) begin
    if (state == ST_SHIFT && sample_edge) begin
      // one bit in per serial period
      if (op_mode == `SSU1_OP_16BIT) begin
        // upper byte joins the shift
        // data pin read directly: a one cycle clock half would miss a flopped copy
        data_upper_byte <= {serial_in_pin, data_upper_byte[7:1]};
        data_lower_byte <= {data_upper_byte[0], data_lower_byte[7:1]};
      end else begin
        // lower byte holds the 8-bit word
        data_lower_byte <= {serial_in_pin, data_lower_byte[7:1]};
      end
    end else if (!busy) begin
      if (wr_upper) begin
        data_upper_byte <= wr_data;
      end
      if (wr_lower) begin
        data_lower_byte <= wr_data;
      end
    end
  end

  // done flag, end of transfer beats a clear
  always @(posedge ref_clk) begin
    if (rst) begin
      done <= 1'b0;
    end else if (finish && !tail_mark_enable) begin
      done <= 1'b1;
    end else if (state == ST_TAIL && half_tick && tail_half == 2'h1) begin
      done <= 1'b1;
    end else if (wr_stat && !wr_data[`SSU1_STAT_DONE]) begin
      done <= 1'b0;
    end else if (start_req) begin
      done <= 1'b0;
    end
  end

  // read data one cycle after the strobe
  always @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      if (ssu1_hit(addr, `SSU1_ADDR_MODE)) begin
        rd_data <= mode;
      end else if (ssu1_hit(addr, `SSU1_ADDR_STAT)) begin
        rd_data <= {busy, done, 5'h00, serial_out_pin};
      end else if (ssu1_hit(addr, `SSU1_ADDR_UPPER)) begin
        rd_data <= data_upper_byte;
      end else if (ssu1_hit(addr, `SSU1_ADDR_LOWER)) begin
        rd_data <= data_lower_byte;
      end else begin
        rd_data <= 8'h00;
      end
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule

// >>> shared/ssu1_regs.vh
// register map, field layout and codes of the synchronous serial unit
`ifndef SSU1_REGS_VH
`define SSU1_REGS_VH

// register addresses
`define SSU1_ADDR_MODE 16'hFFA0
`define SSU1_ADDR_STAT 16'hFFA1
`define SSU1_ADDR_UPPER 16'hFFA2
`define SSU1_ADDR_LOWER 16'hFFA3

// reset values
`define SSU1_MODE_RESET 8'h00
`define SSU1_STAT_RESET 8'h01

// mode register field positions
`define SSU1_OP_MODE_HI 7
`define SSU1_OP_MODE_LO 6
`define SSU1_TAIL_MARK_ENABLE 5
`define SSU1_TAIL_KIND_SELECT 4
`define SSU1_CLOCK_SOURCE_SELECT 3
`define SSU1_PRESCALE_SEL_2 2
`define SSU1_PRESCALE_SEL_0 0

// status register field positions
`define SSU1_STAT_RUN 7
`define SSU1_STAT_DONE 6
`define SSU1_STAT_EXT_DATA 0

// operation mode codes
`define SSU1_OP_8BIT 2'h0
`define SSU1_OP_16BIT 2'h1
`define SSU1_OP_CONT 2'h2
`define SSU1_OP_RSVD 2'h3

// last bit index per word length
`define SSU1_LAST_BIT_8 4'h7
`define SSU1_LAST_BIT_16 4'hF

`endif

// >>> core/ssu1_prescaler.v
// prescaler giving half serial clock ticks from the system clock
`timescale 1ns/1ps
module ssu1_prescaler (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // control
  input wire run,
  input wire [2:0] sel,
  // half period tick
  output reg half_tick
);
  reg [8:0] count;
  wire [8:0] mask;

  function [8:0] ssu1_half_mask;
    input [2:0] s;
    begin
      case (s)
        3'h0: ssu1_half_mask = 9'h1FF;
        3'h1: ssu1_half_mask = 9'h07F;
        3'h2: ssu1_half_mask = 9'h01F;
        3'h3: ssu1_half_mask = 9'h00F;
        3'h4: ssu1_half_mask = 9'h007;
        3'h5: ssu1_half_mask = 9'h003;
        3'h6: ssu1_half_mask = 9'h001;
        default: ssu1_half_mask = 9'h000;
      endcase
    end
  endfunction

  assign mask = ssu1_half_mask(sel);

  always @(posedge ref_clk) begin
    if (rst || !run) begin
      count <= 9'h000;
      half_tick <= 1'b0;
    end else begin
      count <= count + 9'h001;
      half_tick <= ((count & mask) == mask);
    end
  end
endmodule

// >>> dv/ssu1_checker.sv
// port assertions for the serial unit
`timescale 1ns/1ps
`include "ssu1_regs.vh"
module ssu1_checker (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register port
  input wire [15:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rd_data,
  // serial pins
  input wire serial_clock_pin_in,
  input wire serial_clock_pin_out,
  input wire serial_clock_pin_oe,
  input wire serial_in_pin,
  input wire serial_out_pin,
  // status
  input wire busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  reg [7:0] md;
  reg [4:0] cnt;
  reg [10:0] hc;
  reg pk;
  reg pb;
  wire sw = wr_en && addr == `SSU1_ADDR_STAT && !busy;
  wire go = sw && wr_data[7];
  wire [10:0] hp = md[2:0] == 3'h0 ? 11'h200 : md[2:0] == 3'h1 ? 11'h080 :
    11'h040 >> (md[2:0] - 3'h1);
  always @(posedge ref_clk) begin
    pk <= serial_clock_pin_out;
    pb <= busy;
    hc <= serial_clock_pin_out != pk ? 11'h001 : hc + 11'h001;
    if (rst) begin
      md <= 8'h00;
      cnt <= 5'h00;
    end else begin
      if (wr_en && addr == `SSU1_ADDR_MODE && !busy)
        md <= wr_data;
      if (go)
        cnt <= 5'h00;
      else if ((busy || pb) && serial_clock_pin_out && !pk)
        cnt <= cnt + 5'h01;
    end
  end
  a_rd_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data not idle");
  a_ext_read: assert property (rd_en && addr == `SSU1_ADDR_STAT |=>
    rd_data[0] == $past(serial_out_pin) && rd_data[7] == $past(busy))
    else $error("status read wrong");
  a_ext_drive: assert property (sw |=> serial_out_pin == $past(wr_data[0]))
    else $error("out pin not driven");
  a_pin_dir: assert property (serial_clock_pin_oe == !$past(md[3]))
    else $error("clock pin direction");
  a_start_busy: assert property (go && md[7:6] != 2'h3 |=> busy)
    else $error("start ignored");
  a_rsvd_idle: assert property (go && md[7:6] == 2'h3 |=> !busy[*2])
    else $error("reserved mode ran");
  a_word_len: assert property ($fell(busy) && !md[7] && !md[3] |=>
    cnt == (md[6] ? 5'h10 : 5'h08))
    else $error("word length");
  a_half_per: assert property (busy && !md[3] && serial_clock_pin_out && !pk |-> hc == hp)
    else $error("clock division");
endmodule
bind ssu1_core ssu1_checker ssu1_checker_i (.ref_clk(ref_clk), .rst(rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe(serial_clock_pin_oe), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .busy(busy));

// >>> dv/ssu1_peer.sv
// serial peripheral on the far side
`timescale 1ns/1ps
module ssu1_peer (
  // serial link
  input wire sck,
  input wire so,
  output logic si = 1'b1,
  output logic ext_sck = 1'b1
);
  logic [15:0] tx;
  logic [15:0] rx;
  always @(negedge sck) begin
    si <= tx[0];
    tx <= {~tx[0], tx[15:1]};
  end
  always @(posedge sck)
    rx <= {so, rx[15:1]};
  task burst(input int n);
    repeat (n) begin
      #110 ext_sck = 1'b0;
      #110 ext_sck = 1'b1;
    end
  endtask
endmodule

// >>> dv/testbench.sv
// self-checking bench for the serial unit
`timescale 1ns/1ps
`include "ssu1_regs.vh"
module testbench;
  localparam logic [15:0] MD = `SSU1_ADDR_MODE, ST = `SSU1_ADDR_STAT;
  localparam logic [15:0] UP = `SSU1_ADDR_UPPER, LO = `SSU1_ADDR_LOWER;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  wire [7:0] rd_data;
  wire sck_out, sck_oe, si, so, busy, ext_sck;
  wire sck = sck_oe ? sck_out : ext_sck;
  int fail_count = 0;
  int check_count = 0;
  int n;
  logic [7:0] rv;
  logic [15:0] w, r;
  always #10 ref_clk = ~ref_clk;
  ssu1_core ssu1_core_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .serial_clock_pin_in(sck),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe), .serial_in_pin(si),
    .serial_out_pin(so), .busy(busy));
  ssu1_peer ssu1_peer_i (.sck(sck), .so(so), .si(si), .ext_sck(ext_sck));
  task chk(input string nm, input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask
  task rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task idle;
    n = 0;
    while (busy !== 1'b0 && n < 30000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("busy", busy, 1'b0);
  endtask
  task xfer(input logic [7:0] m, input logic ext);
    int len;
    len = m[6] ? 16 : 8;
    w = $urandom;
    r = $urandom;
    wr(MD, m);
    wr(LO, w[7:0]);
    wr(UP, w[15:8]);
    ssu1_peer_i.tx = r;
    wr(ST, 8'h80);
    wr(LO, ~w[7:0]);
    if (ext)
      ssu1_peer_i.burst(len);
    idle();
    rd(ST, rv);
    chk("done", rv[7:6], 2'h1);
    rd(LO, rv);
    chk("lower", rv, r[7:0]);
    if (len == 16) begin
      rd(UP, rv);
      chk("upper", rv, r[15:8]);
      chk("peer word", ssu1_peer_i.rx, w);
    end else
      chk("peer byte", ssu1_peer_i.rx[15:8], w[7:0]);
    chk("tail", so, m[5] ? m[4] : w[len-1]);
  endtask
  initial begin
    void'($urandom(11721));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    rd(MD, rv);
    chk("mode reset", rv, `SSU1_MODE_RESET);
    rd(ST, rv);
    chk("status reset", rv, `SSU1_STAT_RESET);
    rd(16'hFFA7, rv);
    chk("unmapped", rv, 8'h00);
    rv = $urandom & 8'h7F;
    wr(MD, rv);
    rd(MD, w[7:0]);
    chk("mode rw", w[7:0], rv);
    for (int b = 0; b < 2; b++) begin
      wr(ST, b[7:0]);
      chk("out pin", so, b[0]);
      rd(ST, rv);
      chk("ext read", rv[0], b[0]);
    end
    for (int c = 0; c < 8; c++)
      xfer({5'h00, c[2:0]}, 1'b0);
    xfer(8'h75, 1'b0);
    xfer(8'h65, 1'b0);
    xfer(8'h45, 1'b0);
    xfer(8'h35, 1'b0);
    wr(MD, 8'h08);
    @(posedge ref_clk);
    #1 chk("pin input", sck_oe, 1'b0);
    xfer(8'h08, 1'b1);
    wr(MD, 8'hC5);
    wr(ST, 8'h80);
    chk("reserved", busy, 1'b0);
    chk("pin output", sck_oe, 1'b1);
    wr(MD, 8'h87);
    wr(ST, 8'h80);
    repeat (20) @(posedge ref_clk);
    #1 chk("continuous", busy, 1'b1);
    wr(ST, 8'h00);
    idle();
    rd(ST, rv);
    chk("done clear", rv[7:6], 2'h0);
    print_verdict();
  end
  initial begin
    #1000000;
    fail_count++;
    print_verdict();
  end
endmodule
